/* File: hdl/sel_map.vh */
// Constants for the sensor exposure and row-valid timing block.
// Assumes a single clock; included by bare name from the design file.
//
// Behaviour
// [R1] Format field picks one of three row-strobe shapes
// [R2] Third format: continuous strobe XOR field strobe
// [R3] Exposure from shutter rows plus sub-row delay
// [R4] Exposure = width x row time - 182 - delay
// [R5] Row time = columns + blanking (+8 border) ticks
// [R6] Shutter beyond frame rows adds blanking rows
// [R7] Effective shutter width clamped to limit registers
// [R8] Delay N removes N master clocks from exposure
// [R9] Software keeps delay below row time minus overhead
// [R10] Excess delay may suppress the image
// [R11] Odd rows integrate first, then even rows
// [R12] Composite output enabled out of reset
// [R13] Standard pin sets default, register can override
// [R14] NTSC pads three black lines at bottom
// [R15] PAL: 480 image rows, 24 black top/bottom
// [R16] External video supplier must send proper stream
// [R17] Software picks flicker-safe exposure multiples
// [R18] Software keeps shutter within frame rows
// [R19] Software leaves video settings at defaults
// [R20] Exposure changes apply at next frame start
`ifndef SEL_MAP_VH
`define SEL_MAP_VH

// Register offsets
`define SEL_REG_CTRL      8'h00
`define SEL_REG_COLW      8'h04
`define SEL_REG_HBLANK    8'h05
`define SEL_REG_SHUTTER   8'h09
`define SEL_REG_DELAY     8'h0c
`define SEL_REG_SW_MIN    8'h13
`define SEL_REG_SW_MAX    8'h14
`define SEL_REG_STATUS    8'h30
`define SEL_REG_EXPO_LO   8'h31
`define SEL_REG_EXPO_HI   8'h32
`define SEL_REG_ROWS      8'h33

// Control field positions
`define SEL_CTRL_VIDEO_EN 0
`define SEL_CTRL_PAL      1
`define SEL_CTRL_EXT      2
`define SEL_CTRL_BORDER   8
`define SEL_CTRL_FMT_HI   15
`define SEL_CTRL_FMT_LO   14

// Row strobe formats
`define SEL_FMT_GATED     2'h0
`define SEL_FMT_CONT      2'h1
`define SEL_FMT_XOR       2'h2

// Reset values
`define SEL_RST_COLW      16'h0280
`define SEL_RST_HB_NTSC   16'h00d2
`define SEL_RST_HB_PAL    16'h00d8
`define SEL_RST_SHUTTER   16'h01d6
`define SEL_RST_SW_MIN    16'h0001
`define SEL_RST_SW_MAX    16'h07ff

// Timing figures, in master clocks, rows or pixels, then the video black level
`define SEL_PIX_MCLK      16'h0002
`define SEL_BORDER_PIX    16'h0008
`define SEL_INT_OVERHEAD  32'h0000_00b6
`define SEL_SH_OVH_NTSC   32'h0000_0164
`define SEL_SH_OVH_PAL    32'h0000_0170
`define SEL_ROWS_NTSC     16'h020d
`define SEL_ROWS_PAL      16'h0271
`define SEL_ACT_NTSC      16'h00f3
`define SEL_ACT_PAL       16'h0108
`define SEL_VBO_NTSC      16'h0013
`define SEL_VBO_PAL       16'h0030
`define SEL_TOP_NTSC      16'h0000
`define SEL_TOP_PAL       16'h0018
`define SEL_IMG_NTSC      16'h01e3
`define SEL_IMG_PAL       16'h01e0
`define SEL_BLACK_LEVEL   8'h10

`endif

/* File: hdl/sel_top.v */
// Row/field strobe generator, exposure calculator and video source mux.
// Assumes a plain register port and sensor pixel data on CLK_I, and asynchronous pins elsewhere.
`timescale 1ns/1ps
`include "sel_map.vh"

module sel_top #(
    parameter PIX_DIV = 2               // Clocks per pixel tick
) (
    input  wire        CLK_I,           // System clock
    input  wire        RST_I,           // Synchronous reset, high
    input  wire [7:0]  ADDR_I,          // Register address
    input  wire [15:0] WR_DATA_I,       // Register write data
    input  wire        WR_I,            // Write strobe
    input  wire        RD_I,            // Read strobe
    output reg  [15:0] RD_DATA_O,       // Read data, cycle after strobe
    input  wire        STD_PAL_PIN_I,   // Broadcast standard pin, high = PAL
    input  wire [7:0]  PIX_DATA_I,      // Sensor pixel data, same clock
    input  wire [7:0]  EXT_DATA_I,      // External video pins
    output reg         PIX_TICK_O,      // One pulse per pixel tick
    output reg         ROW_STROBE_O,    // Row-valid output
    output reg         FIELD_STROBE_O,  // Field-valid output
    output reg         ODD_FIELD_O,     // High during odd field
    output reg  [9:0]  ROW_ADDR_O,      // Sensor row being read
    output reg         BLACK_ROW_O,     // Current row is black padding
    output reg  [7:0]  VIDEO_DATA_O,    // Data to the encoder
    output reg         VIDEO_EN_O,      // Composite output enable
    output reg         STD_PAL_O        // Active standard, high = PAL
);

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    // Larger of two 16-bit values
    function [15:0] sel_max;
        input [15:0] a;
        input [15:0] b;
        begin
            sel_max = (a > b) ? a : b;
        end
    endfunction

    // Per-standard selection of a 16-bit constant
    function [15:0] sel_std;
        input        pal;
        input [15:0] n;
        input [15:0] p;
        begin
            sel_std = pal ? p : n;
        end
    endfunction

    //------------------------------------------------------------
    // Register state
    //------------------------------------------------------------
    reg  [15:0] ctrl_r;                 // Control word
    reg  [15:0] colw_r;                 // Column width, pixels
    reg  [15:0] hblank_r;               // Row blank count, pixels
    reg  [15:0] shutter_r;              // Shutter width, rows
    reg  [15:0] delay_r;                // Shutter delay, master clocks
    reg  [15:0] sw_min_r;               // Shutter lower limit
    reg  [15:0] sw_max_r;               // Shutter upper limit
    reg  [2:0]  pin_q_r;                // Standard pin synchroniser
    reg  [7:0]  ext_q1_r;               // External data, first stage
    reg  [7:0]  ext_q2_r;               // External data, second stage
    reg  [7:0]  ext_q3_r;               // External data, third stage
    reg  [7:0]  ext_data_r;             // Accepted external byte

    wire        pal      = ctrl_r[`SEL_CTRL_PAL];
    wire        border   = ctrl_r[`SEL_CTRL_BORDER];
    wire [1:0]  fmt      = ctrl_r[`SEL_CTRL_FMT_HI:`SEL_CTRL_FMT_LO];
    wire        pin_ok   = (pin_q_r[1] == pin_q_r[2]);

    // Synchronisers run free; only the agreed value is used.
    // The pin and the external byte come from other clock domains.
    // Each passes three stages, and a value is accepted only once
    // stages two and three agree, so a byte caught mid-change is
    // never passed on. Limitation: the external stream must hold
    // each byte for at least two clocks or bytes are dropped.
    always @(posedge CLK_I) begin
        pin_q_r  <= {pin_q_r[1:0], STD_PAL_PIN_I};
        ext_q1_r <= EXT_DATA_I;
        ext_q2_r <= ext_q1_r;
        ext_q3_r <= ext_q2_r;
        // Byte taken only when stages two and three agree
        if (ext_q2_r == ext_q3_r) begin
            ext_data_r <= ext_q3_r;
        end
    end

    //------------------------------------------------------------
    // Register writes
    //------------------------------------------------------------
    // Standard pin is captured while reset is held, so software
    // sees the strapped default without any write.
    always @(posedge CLK_I) begin
        if (RST_I) begin
            // [R12] Video on by default
            ctrl_r    <= 16'h0001 | (16'h0001 << `SEL_CTRL_BORDER);
            colw_r    <= `SEL_RST_COLW;
            shutter_r <= `SEL_RST_SHUTTER;
            delay_r   <= 16'h0000;
            sw_min_r  <= `SEL_RST_SW_MIN;
            sw_max_r  <= `SEL_RST_SW_MAX;
            // [R13] Pin sets default standard
            if (pin_ok) begin
                ctrl_r[`SEL_CTRL_PAL] <= pin_q_r[2];
                hblank_r <= sel_std(pin_q_r[2], `SEL_RST_HB_NTSC, `SEL_RST_HB_PAL);
            end else begin
                hblank_r <= `SEL_RST_HB_NTSC;
            end
        end else if (WR_I) begin
            // [R13] Standard reachable as register
            if (ADDR_I == `SEL_REG_CTRL) begin
                ctrl_r <= WR_DATA_I;
            end else if (ADDR_I == `SEL_REG_COLW) begin
                colw_r <= WR_DATA_I;
            end else if (ADDR_I == `SEL_REG_HBLANK) begin
                hblank_r <= WR_DATA_I;
            end else if (ADDR_I == `SEL_REG_SHUTTER) begin
                // [R3] Shutter width in rows
                shutter_r <= WR_DATA_I;
            end else if (ADDR_I == `SEL_REG_DELAY) begin
                // [R3] Sub-row delay
                delay_r <= WR_DATA_I;
            end else if (ADDR_I == `SEL_REG_SW_MIN) begin
                sw_min_r <= WR_DATA_I;
            end else if (ADDR_I == `SEL_REG_SW_MAX) begin
                sw_max_r <= WR_DATA_I;
            end
        end
    end

    //------------------------------------------------------------
    // Settings taken at frame start
    //------------------------------------------------------------
    reg  [15:0] sw_f_r;                 // Clamped shutter width
    reg  [15:0] delay_f_r;              // Delay in use
    reg  [15:0] rt_pix_f_r;             // Row time in pixel ticks
    reg  [15:0] colw_f_r;               // Active pixels per row
    reg  [15:0] rows_f_r;               // Rows in this frame
    reg         pal_f_r;                // Standard in use
    reg  [31:0] expo_r;                 // Exposure, master clocks
    reg         no_image_r;             // Delay beyond its maximum

    // Exposure arithmetic runs every cycle on the live registers;
    // only the frame-end edge copies the results, so software may
    // write the settings in any order within a frame.
    // [R7] Clamp to limit registers
    wire [15:0] sw_eff = (shutter_r < sw_min_r) ? sw_min_r :
                         (shutter_r > sw_max_r) ? sw_max_r : shutter_r;
    // [R5] Row time with optional border
    wire [15:0] rt_pix = colw_r + hblank_r + (border ? `SEL_BORDER_PIX : 16'h0000);
    wire [15:0] std_rows = sel_std(pal, `SEL_ROWS_NTSC, `SEL_ROWS_PAL);
    wire [31:0] rt_mclk = rt_pix * `SEL_PIX_MCLK;
    // [R4] Width times row time
    wire [31:0] expo_raw = sw_eff * rt_mclk;
    // [R8] Delay N removes N clocks
    wire [31:0] expo_sub = `SEL_INT_OVERHEAD + {16'h0000, delay_r};
    // Maximum delay uses the borderless row time
    wire [31:0] rt_nb    = (colw_r + hblank_r) * `SEL_PIX_MCLK;
    wire [31:0] sh_ovh   = pal ? `SEL_SH_OVH_PAL : `SEL_SH_OVH_NTSC;

    //------------------------------------------------------------
    // Pixel and row counters
    //------------------------------------------------------------
    // Divider, column and row counters; the row counter restarts at
    // the frame-end edge, the same edge that loads the next settings.
    reg  [7:0]  div_r;                  // Pixel tick divider
    reg  [15:0] col_r;                  // Pixel within row
    reg  [15:0] row_r;                  // Row within frame
    wire [31:0] div_last  = PIX_DIV - 1; // Last divider count
    wire        tick      = ({24'h000000, div_r} == div_last);
    wire        row_end   = tick && (col_r >= rt_pix_f_r - 16'h0001);
    wire        frame_end = row_end && (row_r >= rows_f_r - 16'h0001);

    always @(posedge CLK_I) begin
        if (RST_I) begin
            div_r <= 8'h00;
            col_r <= 16'h0000;
            row_r <= 16'h0000;
        end else begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            if (row_end) begin
                col_r <= 16'h0000;
                row_r <= frame_end ? 16'h0000 : row_r + 16'h0001;
            end else if (tick) begin
                col_r <= col_r + 16'h0001;
            end
        end
    end

    // Load frame settings; a frame never mixes two exposures
    always @(posedge CLK_I) begin
        if (RST_I) begin
            sw_f_r     <= `SEL_RST_SHUTTER;
            delay_f_r  <= 16'h0000;
            rt_pix_f_r <= `SEL_RST_COLW + `SEL_RST_HB_NTSC + `SEL_BORDER_PIX;
            colw_f_r   <= `SEL_RST_COLW;
            rows_f_r   <= `SEL_ROWS_NTSC;
            pal_f_r    <= 1'b0;
            expo_r     <= 32'h0000_0000;
            no_image_r <= 1'b0;
        end else if (frame_end) begin
            // [R20] Apply at frame start
            sw_f_r     <= sw_eff;
            delay_f_r  <= delay_r;
            rt_pix_f_r <= rt_pix;
            colw_f_r   <= colw_r + (border ? `SEL_BORDER_PIX : 16'h0000);
            pal_f_r    <= pal;
            // [R6] Long shutter stretches frame
            rows_f_r   <= sel_max(std_rows, sw_eff);
            // [R4] Floor at zero
            expo_r     <= (expo_raw > expo_sub) ? expo_raw - expo_sub : 32'h0000_0000;
            // [R10] Delay beyond maximum
            no_image_r <= ({16'h0000, delay_r} + sh_ovh > rt_nb);
        end
    end

    //------------------------------------------------------------
    // Field layout
    //------------------------------------------------------------
    // Rows 0 to act-1 are the odd field, then the odd blanking rows,
    // then the even field; the rows after that up to the frame end
    // are blanking, which is where a long shutter adds its rows.
    wire [15:0] act     = sel_std(pal_f_r, `SEL_ACT_NTSC, `SEL_ACT_PAL);
    wire [15:0] vbo     = sel_std(pal_f_r, `SEL_VBO_NTSC, `SEL_VBO_PAL);
    wire [15:0] top     = sel_std(pal_f_r, `SEL_TOP_NTSC, `SEL_TOP_PAL);
    wire [15:0] img     = sel_std(pal_f_r, `SEL_IMG_NTSC, `SEL_IMG_PAL);
    wire [15:0] even_st = act + vbo;
    // [R11] Odd field first
    wire        in_odd  = (row_r < act);
    wire        in_even = (row_r >= even_st) && (row_r < even_st + act);
    wire [15:0] fld_row = in_odd ? row_r : row_r - even_st;
    // Interleaved picture line, odd field on even-numbered lines
    wire [15:0] line    = {fld_row[14:0], in_even};
    // [R14] [R15] Black padding rows
    wire        black   = (line < top) || (line >= top + img);
    // [R10] Suppress image when delay too long
    wire        fld_on  = (in_odd || in_even) && !no_image_r;
    wire        pix_on  = (col_r < colw_f_r);

    // Row strobe shape
    reg         row_nxt;
    always @* begin
        // [R1] Format select
        case (fmt)
            `SEL_FMT_CONT: begin
                row_nxt = pix_on;
            end
            `SEL_FMT_XOR: begin
                // [R2] Continuous XOR field
                row_nxt = pix_on ^ fld_on;
            end
            default: begin
                row_nxt = pix_on && fld_on;
            end
        endcase
    end

    //------------------------------------------------------------
    // Registered outputs
    //------------------------------------------------------------
    // Outputs follow the counters by one cycle
    always @(posedge CLK_I) begin
        if (RST_I) begin
            PIX_TICK_O     <= 1'b0;
            ROW_STROBE_O   <= 1'b0;
            FIELD_STROBE_O <= 1'b0;
            ODD_FIELD_O    <= 1'b0;
            ROW_ADDR_O     <= 10'h000;
            BLACK_ROW_O    <= 1'b0;
            VIDEO_DATA_O   <= 8'h00;
            VIDEO_EN_O     <= 1'b1;
            STD_PAL_O      <= 1'b0;
        end else begin
            PIX_TICK_O     <= tick;
            ROW_STROBE_O   <= row_nxt;
            FIELD_STROBE_O <= fld_on;
            ODD_FIELD_O    <= in_odd;
            // [R11] Odd rows 2k+1, even rows 2k
            ROW_ADDR_O     <= {fld_row[8:0], in_odd};
            BLACK_ROW_O    <= fld_on && black;
            // [R12] Output enable from register
            VIDEO_EN_O     <= ctrl_r[`SEL_CTRL_VIDEO_EN];
            STD_PAL_O      <= pal_f_r;
            // External stream bypasses sensor and padding
            if (ctrl_r[`SEL_CTRL_EXT]) begin
                VIDEO_DATA_O <= ext_data_r;
            end else if (!fld_on || black) begin
                VIDEO_DATA_O <= `SEL_BLACK_LEVEL;
            end else begin
                VIDEO_DATA_O <= PIX_DATA_I;
            end
        end
    end

    //------------------------------------------------------------
    // Register reads
    //------------------------------------------------------------
    // The two exposure halves are not latched together; both stay
    // fixed for a whole frame, so read them within one frame.
    // Data stands only in the cycle after the strobe
    always @(posedge CLK_I) begin
        if (RST_I) begin
            RD_DATA_O <= 16'h0000;
        end else if (!RD_I) begin
            RD_DATA_O <= 16'h0000;
        end else if (ADDR_I == `SEL_REG_CTRL) begin
            RD_DATA_O <= ctrl_r;
        end else if (ADDR_I == `SEL_REG_COLW) begin
            RD_DATA_O <= colw_r;
        end else if (ADDR_I == `SEL_REG_HBLANK) begin
            RD_DATA_O <= hblank_r;
        end else if (ADDR_I == `SEL_REG_SHUTTER) begin
            RD_DATA_O <= shutter_r;
        end else if (ADDR_I == `SEL_REG_DELAY) begin
            RD_DATA_O <= delay_r;
        end else if (ADDR_I == `SEL_REG_SW_MIN) begin
            RD_DATA_O <= sw_min_r;
        end else if (ADDR_I == `SEL_REG_SW_MAX) begin
            RD_DATA_O <= sw_max_r;
        end else if (ADDR_I == `SEL_REG_STATUS) begin
            RD_DATA_O <= {13'h0000, in_odd, pal_f_r, no_image_r};
        end else if (ADDR_I == `SEL_REG_EXPO_LO) begin
            RD_DATA_O <= expo_r[15:0];
        end else if (ADDR_I == `SEL_REG_EXPO_HI) begin
            RD_DATA_O <= expo_r[31:16];
        end else if (ADDR_I == `SEL_REG_ROWS) begin
            RD_DATA_O <= rows_f_r;
        end else begin
            // Unmapped addresses read zero
            RD_DATA_O <= 16'h0000;
        end
    end

endmodule // sel_top

/* File: test/sel_host.sv */
// Host register master model for the sensor timing block.
// Assumes the slave answers a read in the following cycle only.
`timescale 1ns/1ps
module sel_host (
    input  wire        clk_i,
    input  wire [15:0] rd_data_i,
    output reg  [7:0]  addr_o = 8'h00,
    output reg  [15:0] wr_data_o = 16'h0000,
    output reg         wr_o = 1'b0,
    output reg         rd_o = 1'b0
);
    // Write: strobe for one edge, then an idle edge so no signal is set twice
    task wr(input [7:0] a, input [15:0] d);
        begin
            addr_o    <= a;
            wr_data_o <= d;
            wr_o      <= 1'b1;
            @(posedge clk_i);
            wr_o <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    // Read: data stands only in the cycle after the strobe
    task rd(input [7:0] a, output [15:0] d);
        begin
            addr_o <= a;
            rd_o   <= 1'b1;
            @(posedge clk_i);
            rd_o <= 1'b0;
            // Taken at the closing edge, before the slave clears it
            @(posedge clk_i);
            d = rd_data_i;
        end
    endtask
endmodule // sel_host

/* File: test/sel_top_monitor.sv */
// Checker for the row/field timing block, bound to its top module.
// Assumes the control word at 0x00: format [15:14], ext [2], enable [0].
`timescale 1ns/1ps
module sel_top_monitor #(
    parameter PIX_DIV = 2
) (
    input wire        CLK_I,
    input wire        RST_I,
    input wire [7:0]  ADDR_I,
    input wire [15:0] WR_DATA_I,
    input wire        WR_I,
    input wire        RD_I,
    input wire [15:0] RD_DATA_O,
    input wire        PIX_TICK_O,
    input wire        ROW_STROBE_O,
    input wire        FIELD_STROBE_O,
    input wire        ODD_FIELD_O,
    input wire [9:0]  ROW_ADDR_O,
    input wire        BLACK_ROW_O,
    input wire [7:0]  VIDEO_DATA_O,
    input wire        VIDEO_EN_O
);
    reg [1:0] fmt_r; // Shadow of the strobe format field
    reg       ext_r; // Shadow of the external video select
    // Shadows follow control writes; reset matches the default word
    always @(posedge CLK_I) begin
        if (RST_I) begin
            fmt_r <= 2'h0;
            ext_r <= 1'b0;
        end else if (WR_I && ADDR_I == 8'h00) begin
            fmt_r <= WR_DATA_I[15:14];
            ext_r <= WR_DATA_I[2];
        end
    end
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    property p_en_copy;
        logic en;
        (WR_I && ADDR_I == 8'h00, en = WR_DATA_I[0]) |-> ##2 VIDEO_EN_O == en;
    endproperty
    a_read_slot: assert property (RD_DATA_O != 16'h0000 |-> $past(RD_I))
        else $error("read data outside its slot");
    a_reset_outputs: assert property ($fell(RST_I) |-> VIDEO_EN_O && !FIELD_STROBE_O)
        else $error("outputs wrong after reset");
    a_enable_copy: assert property (p_en_copy)
        else $error("video enable does not follow control");
    a_tick_period: assert property (PIX_TICK_O |-> ##PIX_DIV PIX_TICK_O)
        else $error("pixel tick spacing wrong");
    a_gated_field: assert property (fmt_r == 2'h0 && $past(fmt_r) == 2'h0 && ROW_STROBE_O |-> FIELD_STROBE_O)
        else $error("gated row strobe outside field");
    a_odd_addr: assert property (FIELD_STROBE_O && ODD_FIELD_O |-> ROW_ADDR_O[0])
        else $error("odd field reads an even row");
    a_even_addr: assert property (FIELD_STROBE_O && !ODD_FIELD_O |-> !ROW_ADDR_O[0])
        else $error("even field reads an odd row");
    a_odd_in_field: assert property (ODD_FIELD_O || BLACK_ROW_O |-> FIELD_STROBE_O)
        else $error("field flags outside active rows");
    a_black_level: assert property (BLACK_ROW_O && !ext_r && !$past(ext_r) |-> VIDEO_DATA_O == 8'h10)
        else $error("black row not at black level");
    c_xor_active: cover property (fmt_r == 2'h2 && FIELD_STROBE_O && ROW_STROBE_O);
    c_black_row: cover property (BLACK_ROW_O && ROW_STROBE_O);
    c_ext_video: cover property (ext_r && VIDEO_EN_O);
endmodule // sel_top_monitor
bind sel_top sel_top_monitor #(.PIX_DIV(PIX_DIV)) u_mon (.CLK_I(CLK_I), .RST_I(RST_I),
    .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I), .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O),
    .PIX_TICK_O(PIX_TICK_O), .ROW_STROBE_O(ROW_STROBE_O), .FIELD_STROBE_O(FIELD_STROBE_O),
    .ODD_FIELD_O(ODD_FIELD_O), .ROW_ADDR_O(ROW_ADDR_O), .BLACK_ROW_O(BLACK_ROW_O),
    .VIDEO_DATA_O(VIDEO_DATA_O), .VIDEO_EN_O(VIDEO_EN_O));

/* File: test/sel_top_bench.sv */
// Self-checking bench for the row/field timing block.
// Assumes the host model for register cycles; first frame is the long default.
`timescale 1ns/1ps
module sel_top_bench;
    localparam RT = 400;        // Clocks per row: (100 + 92 + 8) ticks of 2
    localparam RL = 216;        // Row strobe clocks per row: (100 + 8) ticks of 2
    localparam LIMIT = 1600000; // Default frame alone is 900900 clocks
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         pin = 1'b0;
    reg  [7:0]  pix = 8'ha5;
    reg  [7:0]  ext = 8'h5a;    // Stable external byte from the supplier
    wire [7:0]  addr, vd_w;
    wire [15:0] wdat, rdat;
    wire        wr, rd, rs_w, fs_w, odd_w, blk_w, ven_w, pal_w;
    integer     n_errors = 0;
    integer     compares = 0;
    integer     cyc = 0;
    always #2 clk = ~clk;
    sel_host HOST (.clk_i(clk), .rd_data_i(rdat), .addr_o(addr), .wr_data_o(wdat),
        .wr_o(wr), .rd_o(rd));
    sel_top #(.PIX_DIV(2)) DUT (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_DATA_I(wdat),
        .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdat), .STD_PAL_PIN_I(pin), .PIX_DATA_I(pix),
        .EXT_DATA_I(ext), .PIX_TICK_O(), .ROW_STROBE_O(rs_w), .FIELD_STROBE_O(fs_w),
        .ODD_FIELD_O(odd_w), .ROW_ADDR_O(), .BLACK_ROW_O(blk_w), .VIDEO_DATA_O(vd_w),
        .VIDEO_EN_O(ven_w), .STD_PAL_O(pal_w));
    task give_verdict;
        begin
            if (n_errors == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task rdc(input [7:0] a, input [31:0] exp);
        reg [15:0] d;
        begin
            HOST.rd(a, d);
            chk({16'h0000, d}, exp);
        end
    endtask
    // Counts one frame from this odd field start to the next one
    task scan(input [31:0] rows_e, input [31:0] blk_e, input [31:0] odd_e, input [31:0] len_e);
        reg [31:0] rows, blk, oddn, hi, len;
        reg        pr, po;
        begin
            {rows, blk, oddn, hi, len} = 160'h0;
            pr = 1'b0;
            po = 1'b1;
            while (!(odd_w === 1'b1 && !po)) begin
                if (rs_w && !pr) begin
                    rows = rows + 1;
                    blk = blk + blk_w;
                    oddn = oddn + odd_w;
                    chk(vd_w, blk_w ? 8'h10 : 8'ha5);
                end
                hi = hi + rs_w;
                len = len + 1;
                pr = rs_w;
                po = odd_w;
                @(posedge clk);
            end
            chk(rows, rows_e);
            chk(blk, blk_e);
            chk(oddn, odd_e);
            chk(hi, rows_e * RL);
            chk(len, len_e);
        end
    endtask
    // Row strobe high clocks over exactly one row period
    task win(input [31:0] e);
        reg [31:0] hi;
        begin
            hi = 0;
            repeat (4) @(posedge clk);
            repeat (RT) begin
                hi = hi + rs_w;
                @(posedge clk);
            end
            chk(hi, e);
        end
    endtask
    // Cuts a hang short
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: run did not finish", $time);
            give_verdict;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(ven_w, 1'b1);
        rdc(8'h00, 32'h0101);
        rdc(8'h05, 32'h00d2);
        rdc(8'h09, 32'h01d6);
        rdc(8'h14, 32'h07ff);
        rdc(8'h7f, 32'h0000);
        HOST.wr(8'h04, 16'h0064);
        HOST.wr(8'h05, 16'h005c);
        HOST.wr(8'h09, 16'h0300);
        HOST.wr(8'h14, 16'h0233); // 563 x 400 - 182 - 18 = 1/120 s at 27 MHz
        HOST.wr(8'h0c, 16'h0012); // 18 kept under 384 - 356
        rdc(8'h33, 32'h020d);
        while (odd_w !== 1'b0) @(posedge clk);
        while (odd_w !== 1'b1) @(posedge clk);
        fork
            scan(32'd486, 32'd3, 32'd243, 32'd225200);
            begin
                repeat (40) @(posedge clk);
                rdc(8'h31, 32'h6ee8);
                rdc(8'h32, 32'h0003);
                rdc(8'h33, 32'h0233);
                HOST.wr(8'h00, 16'h0103);
                HOST.wr(8'h09, 16'h0005);
                HOST.wr(8'h13, 16'h0010);
                HOST.wr(8'h0c, 16'h0000); // PAL leaves 384 - 368
            end
        join
        fork
            scan(32'd528, 32'd48, 32'd264, 32'd250000);
            begin
                repeat (40) @(posedge clk);
                chk(pal_w, 1'b1);
                rdc(8'h31, 32'h184a);
                rdc(8'h32, 32'h0000);
            end
        join
        HOST.wr(8'h00, 16'h8103);
        win(RT - RL);
        HOST.wr(8'h00, 16'h4103);
        while (fs_w !== 1'b0) @(posedge clk);
        win(RL);
        HOST.wr(8'h00, 16'h0103);
        win(0);
        HOST.wr(8'h00, 16'h0107);
        repeat (6) @(posedge clk);
        chk(vd_w, 8'h5a);
        HOST.wr(8'h00, 16'h0102);
        repeat (2) @(posedge clk);
        chk(ven_w, 1'b0);
        pin <= 1'b1;
        rst <= 1'b1; // back to the default video set-up
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(ven_w, 1'b1);
        rdc(8'h00, 32'h0103);
        give_verdict;
    end
endmodule // sel_top_bench
